// ===== pif_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "pif_consts.svh"
module pif_irq #(
    parameter int TIMER1_WIDTH = 16
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral events, same clock
    input wire pif_pkg::pif_events_t events,
    input wire pif_pkg::pif_levels_t levels,
    input wire pif_pkg::pif_ccmode_t cc_mode,
    input wire logic [TIMER1_WIDTH-1:0] timer1_count,
    // serial data register accesses by the core
    input wire logic rx_data_read,
    input wire logic tx_data_write,
    // requests
    output logic core_irq,
    output logic irq
);
    logic [7:0] flags_q;
    logic [7:0] enable1_q;
    logic enable2_q;
    logic [1:0] control_q;
    logic [7:0] status_q;
    logic [7:0] irqen_q;
    logic [TIMER1_WIDTH-1:0] t1_prev_q;
    logic rx_q;
    logic tx_q;
    logic cc2_pend_q;
    logic [7:0] set_vec;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] wbyte;
    logic t1_roll;
    logic cc1_hit;
    logic req_d;
    logic [7:0] ev_vec;

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
        is_addr = (a == off);
    endfunction : is_addr

    // apb access decode, zero wait states
    assign wr_acc = clk_en && psel && penable && pwrite;
    assign rd_acc = clk_en && psel && penable && !pwrite;
    assign wbyte = pwdata[7:0];

    // rollover from all ones to zero
    assign t1_roll = (&t1_prev_q) && (timer1_count == '0);
    // pwm mode leaves capcmp1 unused
    assign cc1_hit = events.capcmp1_event && (cc_mode != pif_pkg::PIF_CC_PWM);

    // hardware set vector, independent of enables
    always_comb begin
        set_vec = 8'h00;
        set_vec[`PIF_BIT_GATE] = events.timer1_gate;
        set_vec[`PIF_BIT_CONV] = events.converter_done;
        set_vec[`PIF_BIT_SYNC] = events.sync_port_done;
        set_vec[`PIF_BIT_CC1] = cc1_hit;
        set_vec[`PIF_BIT_T2] = events.timer2_match;
        set_vec[`PIF_BIT_T1] = events.timer1_tick || t1_roll;
    end

    // previous timer1 value for rollover detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_prev_q <= '0;
        end else if (clk_en) begin
            t1_prev_q <= timer1_count;
        end
    end

    // sticky flags; set wins over a software write of zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= `PIF_RST_BYTE;
        end else if (clk_en) begin
            if (wr_acc && is_addr(paddr, `PIF_OFF_FLAGS1)) begin
                flags_q <= (wbyte & `PIF_SW_MASK) | set_vec;
            end else begin
                flags_q <= flags_q | set_vec;
            end
        end
    end

    // rx/tx flags mirror the serial buffers; writes ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= 1'b0;
            tx_q <= 1'b0;
        end else if (clk_en) begin
            rx_q <= levels.rx_full && !rx_data_read;
            tx_q <= levels.tx_empty && !tx_data_write;
        end
    end

    // capcmp2 has no flag here; keep a sticky pending bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc2_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (events.capcmp2_event) begin
                cc2_pend_q <= 1'b1;
            end else if (wr_acc && is_addr(paddr, `PIF_OFF_ENABLE2) && pwdata[8]) begin
                cc2_pend_q <= 1'b0;
            end
        end
    end

    // enable and control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable1_q <= `PIF_RST_BYTE;
            enable2_q <= 1'b0;
            control_q <= 2'h0;
            irqen_q <= `PIF_RST_BYTE;
        end else if (wr_acc) begin
            if (is_addr(paddr, `PIF_OFF_ENABLE1)) begin
                enable1_q <= wbyte;
            end
            if (is_addr(paddr, `PIF_OFF_ENABLE2)) begin
                enable2_q <= wbyte[`PIF_BIT_CC2];
            end
            if (is_addr(paddr, `PIF_OFF_CONTROL)) begin
                control_q <= {wbyte[`PIF_BIT_GGATE], wbyte[`PIF_BIT_PGATE]};
            end
            if (is_addr(paddr, `PIF_OFF_IRQEN)) begin
                irqen_q <= wbyte;
            end
        end
    end

    // full view of flags, rx/tx from the live mirrors
    logic [7:0] flags_view;
    always_comb begin
        flags_view = flags_q;
        flags_view[`PIF_BIT_RX] = rx_q;
        flags_view[`PIF_BIT_TX] = tx_q;
    end

    // gated request, both gates needed
    assign req_d = control_q[1] && control_q[0] &&
        (|(flags_view & enable1_q) || (cc2_pend_q && enable2_q));

    // event status for the block interrupt: any new set
    assign ev_vec = set_vec;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `PIF_RST_BYTE;
        end else if (clk_en) begin
            if (wr_acc && is_addr(paddr, `PIF_OFF_CLEAR)) begin
                status_q <= (status_q & ~wbyte) | ev_vec;
            end else begin
                status_q <= status_q | ev_vec;
            end
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_irq <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            core_irq <= req_d;
            irq <= |(status_q & irqen_q);
        end
    end

    // read mux, registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `PIF_OFF_FLAGS1: prdata <= {24'h00_0000, flags_view};
                    `PIF_OFF_ENABLE1: prdata <= {24'h00_0000, enable1_q};
                    `PIF_OFF_ENABLE2: prdata <= {31'h0000_0000, enable2_q};
                    `PIF_OFF_CONTROL: prdata <= {24'h00_0000, control_q, 6'h00};
                    `PIF_OFF_STATUS: prdata <= {24'h00_0000, status_q};
                    `PIF_OFF_IRQEN: prdata <= {24'h00_0000, irqen_q};
                    `PIF_OFF_CLEAR: prdata <= 32'h0000_0000;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // assertions: hardware sets while clk_en is high, independent of the enable registers
    a_flag_set_sticks: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && events.converter_done) |=> flags_q[`PIF_BIT_CONV])
        else $error("converter flag not set");
    a_sync_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && events.sync_port_done) |=> flags_q[`PIF_BIT_SYNC])
        else $error("sync flag not set");
    a_t2_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && events.timer2_match) |=> flags_q[`PIF_BIT_T2])
        else $error("timer2 flag not set");
    a_roll_sets_t1: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && t1_roll) |=> flags_q[`PIF_BIT_T1])
        else $error("rollover missed");
    a_gate_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && events.timer1_gate) |=> flags_q[`PIF_BIT_GATE])
        else $error("gate flag not set");
    a_tick_sets_t1: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && events.timer1_tick) |=> flags_q[`PIF_BIT_T1])
        else $error("timer1 flag not set");
    a_cc1_event_set: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && events.capcmp1_event && cc_mode != pif_pkg::PIF_CC_PWM)
        |=> flags_q[`PIF_BIT_CC1])
        else $error("capcmp1 flag not set");
    a_pwm_no_cc1: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && cc_mode == pif_pkg::PIF_CC_PWM && !flags_q[`PIF_BIT_CC1]
         && !(wr_acc && paddr == `PIF_OFF_FLAGS1)) |=> !flags_q[`PIF_BIT_CC1])
        else $error("capcmp1 set in pwm mode");
    a_set_beats_clr: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_FLAGS1 && events.timer2_match)
        |=> flags_q[`PIF_BIT_T2])
        else $error("clear won over set");
    a_cc2_pend_set: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && events.capcmp2_event) |=> cc2_pend_q)
        else $error("capcmp2 pending not set");

    // assertions: a flag only falls through a software write
    a_flags_stick: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !(wr_acc && paddr == `PIF_OFF_FLAGS1))
        |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flag dropped without a write");
    a_conv_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_FLAGS1 && !pwdata[`PIF_BIT_CONV]
         && !events.converter_done) |=> !flags_q[`PIF_BIT_CONV])
        else $error("converter flag not cleared");
    a_sync_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_FLAGS1 && !pwdata[`PIF_BIT_SYNC]
         && !events.sync_port_done) |=> !flags_q[`PIF_BIT_SYNC])
        else $error("sync flag not cleared");
    a_cc1_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_FLAGS1 && !pwdata[`PIF_BIT_CC1]
         && !events.capcmp1_event) |=> !flags_q[`PIF_BIT_CC1])
        else $error("capcmp1 flag not cleared");
    a_t2_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_FLAGS1 && !pwdata[`PIF_BIT_T2]
         && !events.timer2_match) |=> !flags_q[`PIF_BIT_T2])
        else $error("timer2 flag not cleared");
    a_t1_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_FLAGS1 && !pwdata[`PIF_BIT_T1]
         && !events.timer1_tick && !t1_roll) |=> !flags_q[`PIF_BIT_T1])
        else $error("timer1 flag not cleared");

    // assertions: read-only serial mirrors
    a_rx_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && rx_data_read) |=> !rx_q)
        else $error("rx flag not cleared on read");
    a_tx_write_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && tx_data_write) |=> !tx_q)
        else $error("tx flag not cleared on write");
    a_rx_full_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && levels.rx_full && !rx_data_read) |=> rx_q)
        else $error("rx flag missed a full buffer");
    a_rx_empty_off: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !levels.rx_full) |=> !rx_q)
        else $error("rx flag high with buffer not full");
    a_tx_empty_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && levels.tx_empty && !tx_data_write) |=> tx_q)
        else $error("tx flag missed an empty buffer");
    a_tx_full_off: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !levels.tx_empty) |=> !tx_q)
        else $error("tx flag high with buffer full");

    // assertions: enables, gates and the core request
    a_gate_blocks_req: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !control_q[0]) |=> !core_irq)
        else $error("request passed with gate closed");
    a_ggate_blocks_req: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !control_q[1]) |=> !core_irq)
        else $error("request passed with global gate closed");
    a_req_when_on: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && control_q == 2'h3 && |(flags_view & enable1_q)) |=> core_irq)
        else $error("enabled flag gave no request");
    a_idle_no_req: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && flags_view == 8'h00 && !cc2_pend_q) |=> !core_irq)
        else $error("request with nothing pending");
    a_cc2_gated: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !enable2_q && flags_view == 8'h00) |=> !core_irq)
        else $error("capcmp2 request while disabled");
    a_en2_one_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_ENABLE2) |=> enable2_q == $past(pwdata[`PIF_BIT_CC2]))
        else $error("enable2 write did not land");
    a_en2_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && psel && paddr == `PIF_OFF_ENABLE2) |-> prdata[31:1] == 31'h0000_0000)
        else $error("enable2 upper bits nonzero");
    a_en1_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_ENABLE1) |=> enable1_q == $past(pwdata[7:0]))
        else $error("enable1 write did not land");
    a_read_keeps_cfg: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc |=> $stable(enable1_q) && $stable(control_q) && $stable(irqen_q))
        else $error("read changed a control register");

    // assertions: status, irq, bus answer and clock enable
    a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !(wr_acc && paddr == `PIF_OFF_CLEAR))
        |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("status bit dropped without a clear");
    a_clr_drops_status: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `PIF_OFF_CLEAR && ev_vec == 8'h00)
        |=> (status_q & $past(pwdata[7:0])) == 8'h00)
        else $error("status bit survived its clear");
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && |(status_q & irqen_q)) |=> irq)
        else $error("enabled status gave no irq");
    a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && irqen_q == 8'h00) |=> !irq)
        else $error("irq with every source masked");
    a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && pready) |=> !pready)
        else $error("pready held past the access cycle");
    a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");
    a_idle_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside the access cycle");
    a_freeze_flags: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(flags_q) && $stable(status_q) && $stable(cc2_pend_q))
        else $error("state moved with clock enable low");
    a_freeze_outs: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(core_irq) && $stable(irq) && $stable(pready))
        else $error("output moved with clock enable low");
endmodule : pif_irq
`default_nettype wire

// ===== pif_consts.svh
// Notes on behaviour
// - flags set regardless of enable1 and enable2, but only while clk_en is high
// - no request without peripheral gate set; only core_irq is gated, irq ignores both gates
// - enable2 bit 0 gates capcmp2 request
// - enable2 bits 7..1 read zero, ignore writes
// - converter flag sets on done, sticky
// - rx flag follows buffer full, read-only
// - tx flag follows buffer empty, read-only
// - sync port flag sticky until cleared
// - capcmp1 flag on capture or compare
// - timer2 flag on period match, sticky
// - timer1 flag on overflow, sticky
// - timer1 rollover raises overflow flag
`ifndef PIF_CONSTS_SVH
`define PIF_CONSTS_SVH
`define PIF_OFF_FLAGS1 12'h000
`define PIF_OFF_ENABLE1 12'h004
`define PIF_OFF_ENABLE2 12'h008
`define PIF_OFF_CONTROL 12'h00C
`define PIF_OFF_STATUS 12'h010
`define PIF_OFF_CLEAR 12'h014
`define PIF_OFF_IRQEN 12'h018
`define PIF_BIT_GATE 7
`define PIF_BIT_CONV 6
`define PIF_BIT_RX 5
`define PIF_BIT_TX 4
`define PIF_BIT_SYNC 3
`define PIF_BIT_CC1 2
`define PIF_BIT_T2 1
`define PIF_BIT_T1 0
`define PIF_BIT_CC2 0
`define PIF_BIT_PGATE 6
`define PIF_BIT_GGATE 7
`define PIF_SW_MASK 8'hCF
`define PIF_RST_BYTE 8'h00
`endif

// ===== pif_pkg.sv
package pif_pkg;
    typedef struct packed {
        logic timer1_gate;
        logic converter_done;
        logic sync_port_done;
        logic capcmp1_event;
        logic timer2_match;
        logic timer1_tick;
        logic capcmp2_event;
    } pif_events_t;
    typedef struct packed {
        logic rx_full;
        logic tx_empty;
    } pif_levels_t;
    typedef enum logic [1:0] {
        PIF_CC_CAPTURE = 2'h0,
        PIF_CC_COMPARE = 2'h1,
        PIF_CC_PWM = 2'h3
    } pif_ccmode_t;
endpackage : pif_pkg

// ===== pif_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench requests
    input wire pif_pkg::pif_events_t req,
    input wire logic rx_set,
    input wire logic tx_set,
    // core strobes
    input wire logic rx_data_read,
    input wire logic tx_data_write,
    // toward the block
    output pif_pkg::pif_events_t events,
    output pif_pkg::pif_levels_t levels,
    output logic [15:0] timer1_count
);
    // one-cycle pulses; the count sits at max so a tick is a wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= '0;
            timer1_count <= 16'hFFFF;
        end else begin
            events <= req;
            timer1_count <= events.timer1_tick ? 16'h0000 : 16'hFFFF;
        end
    end
    // buffer levels: a read empties rx, a write fills tx
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            levels <= '0;
        end else begin
            if (rx_set) levels.rx_full <= 1'b1;
            else if (rx_data_read) levels.rx_full <= 1'b0;
            if (tx_set) levels.tx_empty <= 1'b1;
            else if (tx_data_write) levels.tx_empty <= 1'b0;
        end
    end
endmodule : pif_periph_model
`default_nettype wire

// ===== peripheral_irq_flag_enable_tb.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_enable_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, serr, core_irq, irq, rx_set = 0, tx_set = 0;
    logic rx_data_read = 0, tx_data_write = 0, clk_en = 1;
    logic [15:0] timer1_count;
    pif_pkg::pif_events_t req = '0, events;
    pif_pkg::pif_levels_t levels;
    pif_pkg::pif_ccmode_t cc_mode = pif_pkg::PIF_CC_CAPTURE;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    logic [7:0] en;
    logic [6:0] ev;
    // 250 MHz
    always #2 pclk = ~pclk;
    pif_irq u_pif_irq (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .events, .levels, .cc_mode,
        .timer1_count, .rx_data_read, .tx_data_write, .core_irq, .irq);
    pif_periph_model u_pif_periph_model (.pclk, .presetn, .req, .rx_set, .tx_set,
        .rx_data_read, .tx_data_write, .events, .levels, .timer1_count);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // one transfer, then an idle edge so back-to-back calls never collide
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task pulse(input logic [6:0] e);
        req <= e;
        @(posedge pclk);
        req <= '0;
        repeat (3) @(posedge pclk);
    endtask : pulse
    // struct bit order to flag register bit order
    function logic [7:0] to_flags(input logic [6:0] e);
        return {e[6:5], 2'b00, e[4:1]};
    endfunction : to_flags
    task print_verdict;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // hang guard, run needs about 490 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h7950));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, '0);
        chk("flags rst", rd, 32'h0000_0000);
        apb(1'b1, 12'h008, 32'hFFFF_FEFF);
        apb(1'b0, 12'h008, '0);
        chk("enable2", rd, 32'h0000_0001);
        // each source except capcmp2 alone, then cleared by software
        for (int i = 1; i < 7; i++) begin
            ev = 7'h01 << i;
            pulse(ev);
            apb(1'b0, 12'h000, '0);
            chk("flag", rd, {24'h0, to_flags(ev)});
            apb(1'b1, 12'h000, '0);
        end
        cc_mode <= pif_pkg::PIF_CC_PWM;
        pulse(7'h08);
        apb(1'b0, 12'h000, '0);
        chk("pwm cc1", rd, '0);
        cc_mode <= pif_pkg::PIF_CC_COMPARE;
        rx_set <= 1'b1;
        tx_set <= 1'b1;
        @(posedge pclk);
        rx_set <= 1'b0;
        tx_set <= 1'b0;
        apb(1'b1, 12'h000, '0);
        apb(1'b0, 12'h000, '0);
        chk("rx tx", rd, 32'h0000_0030);
        rx_data_read <= 1'b1;
        tx_data_write <= 1'b1;
        @(posedge pclk);
        rx_data_read <= 1'b0;
        tx_data_write <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(1'b0, 12'h000, '0);
        chk("rx tx off", rd, '0);
        // flags are clear before enabling the timer1 source
        apb(1'b1, 12'h004, 32'h0000_0001);
        apb(1'b1, 12'h00C, 32'h0000_0080);
        pulse(7'h02);
        chk("no pgate", core_irq, '0);
        apb(1'b1, 12'h00C, 32'h0000_00C0);
        @(posedge pclk);
        chk("gates on", core_irq, 1);
        apb(1'b1, 12'h00C, 32'h0000_0040);
        @(posedge pclk);
        chk("no ggate", core_irq, '0);
        apb(1'b1, 12'h004, '0);
        apb(1'b1, 12'h008, 32'h0000_0101);
        apb(1'b1, 12'h00C, 32'h0000_00C0);
        pulse(7'h01);
        chk("cc2 on", core_irq, 1);
        apb(1'b1, 12'h008, '0);
        @(posedge pclk);
        chk("cc2 off", core_irq, '0);
        // random sources against random enables
        repeat (24) begin
            ev = 7'($urandom()) & 7'h7E;
            en = 8'($urandom());
            apb(1'b1, 12'h000, '0);
            apb(1'b1, 12'h004, {24'h0, en});
            pulse(ev);
            apb(1'b0, 12'h000, '0);
            chk("rnd flags", rd, {24'h0, to_flags(ev)});
            chk("rnd req", core_irq, |(to_flags(ev) & en));
        end
        // clear write meets a timer2 set in the same cycle: the set survives
        fork
            apb(1'b1, 12'h000, '0);
            pulse(7'h04);
        join
        apb(1'b0, 12'h000, '0);
        chk("set wins", rd, {24'h0, to_flags(7'h04)});
        // an event while the clock enable is low is not seen
        clk_en <= 1'b0;
        pulse(7'h20);
        clk_en <= 1'b1;
        apb(1'b0, 12'h000, '0);
        chk("frozen", rd, {24'h0, to_flags(7'h04)});
        // status, mask and clear path to irq
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        apb(1'b1, 12'h018, 32'h0000_00FF);
        pulse(7'h10);
        chk("irq set", irq, 1);
        apb(1'b1, 12'h018, '0);
        @(posedge pclk);
        chk("irq mask", irq, '0);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        apb(1'b1, 12'h018, 32'h0000_00FF);
        @(posedge pclk);
        chk("irq clr", irq, '0);
        apb(1'b0, 12'h010, '0);
        chk("status", rd, '0);
        apb(1'b0, 12'h020, '0);
        chk("unmapped", serr, 1);
        print_verdict();
    end
endmodule : peripheral_irq_flag_enable_tb
`default_nettype wire
